// ### common/sic_pkg.sv
// Purpose: Shared constants and types for the scan interface control regs.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes:   Bit positions follow the two 16-bit control registers.
package sic_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ONE_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL_TWO_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STS_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_MSK_ADDR = 8'h0c;

  // ==========================================================
  // First control register fields
  // ==========================================================
  localparam int ENABLE_BIT = 0;
  localparam int TEST_BIT = 1;
  localparam int FLAG0_BIT = 2;
  localparam int ONE_W = 3;

  // ==========================================================
  // Second control register fields
  // ==========================================================
  localparam int DAC_FORCE_BIT = 15;
  localparam int CMP_FORCE_BIT = 14;
  localparam int CMP_INV_BIT = 13;
  localparam int CMP_GRP_BIT = 12;
  localparam int SINGLE_SEL_BIT = 11;
  localparam int FIX3_SEL_BIT = 10;
  localparam int CAP_GND_BIT = 9;
  localparam int MID_SUP_BIT = 8;
  localparam int SH_EN_BIT = 7;
  localparam int EXC_EN_BIT = 6;
  localparam int TCH1_LSB = 4;
  localparam int TCH0_LSB = 2;
  localparam int TWO_LSB = 2;
  localparam int TWO_MSB = 15;

  // ==========================================================
  // Interrupt status and mask layout
  // ==========================================================
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_TEST_BIT = 1;
  localparam int IRQ_W = 2;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [ONE_W-1:0] ONE_RST = 3'h0;
  localparam logic [TWO_MSB:TWO_LSB] TWO_RST = 14'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    SIC_R_ONE,
    SIC_R_TWO,
    SIC_R_STS,
    SIC_R_MSK,
    SIC_R_NONE
  } sic_reg_t;

  typedef struct packed {
    logic [ONE_W-1:0] one;
    logic [TWO_MSB:TWO_LSB] two;
    logic [IRQ_W-1:0] sts;
    logic [IRQ_W-1:0] msk;
    logic [31:0] rdata;
    logic slverr;
  } sic_state_t;

endpackage : sic_pkg

// ### logic/sic_comp_mux.sv
// Purpose: Comparator input selection and output polarity.
// Assumes: Analog inputs are modelled as single digital levels.
// Notes:   Purely combinational; a test cycle uses the test channel fields.
module sic_comp_mux
  import sic_pkg::*;
(
  input wire logic grp_in,
  input wire logic single_in,
  input wire logic fix3_in,
  input wire logic invert_in,
  input wire logic test_active_in,
  input wire logic test_chan_in,
  input wire logic [1:0] tch1_sel_in,
  input wire logic [1:0] tch0_sel_in,
  input wire logic [1:0] chan_sel_in,
  input wire logic [3:0] sensor_in,
  input wire logic [3:0] alt_in,
  input wire logic common_in,
  input wire logic comp_raw_in,
  output logic comp_in_out,
  output logic comp_result_out
);

  // Index 3 of the sensor group is alternate input 3 in both groups.
  function automatic logic pick(input logic grp, input logic [1:0] idx,
                                input logic [3:0] sens,
                                input logic [3:0] alt);
    if (grp || idx == 2'h3) begin
      pick = alt[idx];
    end else begin
      pick = sens[idx];
    end
  endfunction : pick

  // ==========================================================
  // Input selection
  // ==========================================================
  // A test cycle overrides the normal path so both test channels can be
  // sampled without disturbing the configured scan selection.
  always_comb begin
    if (test_active_in) begin
      comp_in_out = pick(grp_in, test_chan_in ? tch1_sel_in : tch0_sel_in,
                         sensor_in, alt_in); // [RQ12]
    end else if (!grp_in) begin
      comp_in_out = pick(1'b0, chan_sel_in, sensor_in, alt_in); // [RQ9]
    end else if (single_in) begin
      comp_in_out = common_in; // [RQ10]
    end else if (fix3_in) begin
      comp_in_out = alt_in[3]; // [RQ11]
    end else begin
      comp_in_out = pick(1'b1, chan_sel_in, sensor_in, alt_in); // [RQ11]
    end
  end

  // Output polarity.
  assign comp_result_out = comp_raw_in ^ invert_in; // [RQ8]

endmodule : sic_comp_mux

// ### logic/sic_regs.sv
// Purpose: Control registers of the scan interface behind an APB slave.
// Assumes: Single clock; all inputs synchronous to ref_clk_in.
// Notes:   Reads answer in the access phase with no wait state.
// Notes on behaviour
// [RQ1] Channel event sets the event flag.
// [RQ2] Software clears the flag by writing zero.
// [RQ3] Writing one requests one test cycle.
// [RQ4] Test request self-clears when cycle finishes.
// [RQ5] Bit zero enables the whole interface.
// [RQ6] DAC force bit keeps DAC powered.
// [RQ7] Otherwise DAC follows timing machine.
// [RQ8] Invert bit flips comparator output polarity.
// [RQ9] Group zero routes selected sensor channel; the code routes alternate input 3 instead when the index is 3.
// [RQ10] Single select feeds the common alternate input.
// [RQ11] Fixed bit picks alternate input three.
// [RQ12] Test channel fields pick sampled inputs.
// [RQ13] Low bits report test channel results.
// [RQ14] Mid supply on only without sample-hold.
// [RQ15] Reset clears all writable control bits.
module sic_regs
  import sic_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  // Timing and flag logic.
  input wire logic channel_event_in,
  input wire logic test_cycle_done_in,
  input wire logic test_active_in,
  input wire logic test_chan_in,
  input wire logic tsm_dac_on_in,
  input wire logic tsm_cmp_on_in,
  input wire logic [1:0] chan_sel_in,
  // Analog front end.
  input wire logic [3:0] sensor_channels_in,
  input wire logic [3:0] alternate_inputs_in,
  input wire logic common_alternate_input_in,
  input wire logic comp_raw_in,
  input wire logic test_ch1_result_in,
  input wire logic test_ch0_result_in,
  output logic interface_enable_out,
  output logic test_insert_req_out,
  output logic scan_event_flag0_out,
  output logic dac_power_out,
  output logic cmp_power_out,
  output logic cap_ground_out,
  output logic mid_supply_out,
  output logic sample_hold_out,
  output logic excitation_out,
  output logic comp_in_out,
  output logic comp_result_out,
  output logic irq_out
);

  // ==========================================================
  // Address decode
  // ==========================================================
  // Shared by the read and write paths so both agree on the map.
  function automatic sic_reg_t dec(input logic [ADDR_W-1:0] a);
    case (a)
      CTRL_ONE_ADDR: dec = SIC_R_ONE;
      CTRL_TWO_ADDR: dec = SIC_R_TWO;
      IRQ_STS_ADDR: dec = SIC_R_STS;
      IRQ_MSK_ADDR: dec = SIC_R_MSK;
      default: dec = SIC_R_NONE;
    endcase
  endfunction : dec

  sic_state_t state_q;
  sic_state_t state_d;
  logic setup_w;
  logic wr_w;
  sic_reg_t wsel_w;
  sic_reg_t rsel_w;
  logic test_done_w;

  // Bus phases; a write lands only at the completing access edge.
  assign setup_w = psel_in && !penable_in;
  assign wr_w = psel_in && penable_in && pwrite_in;
  assign wsel_w = dec(paddr_in);
  assign rsel_w = dec(paddr_in);
  assign test_done_w = state_q.one[TEST_BIT] && test_cycle_done_in;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    state_d = state_q;
    // Writable control bits.
    if (wr_w && wsel_w == SIC_R_ONE) begin
      state_d.one = pwdata_in[ONE_W-1:0]; // [RQ3] [RQ5]
    end
    if (wr_w && wsel_w == SIC_R_TWO) begin
      state_d.two = pwdata_in[TWO_MSB:TWO_LSB];
    end
    if (wr_w && wsel_w == SIC_R_MSK) begin
      state_d.msk = pwdata_in[IRQ_W-1:0];
    end
    // Self-clear after the test cycle; a new write of one in the same
    // cycle wins so that request is not lost.
    if (test_done_w && !(wr_w && wsel_w == SIC_R_ONE
                         && pwdata_in[TEST_BIT])) begin
      state_d.one[TEST_BIT] = 1'b0; // [RQ4]
    end
    // Flag is sticky; only a software write of zero clears it, and a
    // simultaneous event keeps it set.
    if (channel_event_in) begin
      state_d.one[FLAG0_BIT] = 1'b1; // [RQ1] [RQ2]
    end
    // Interrupt status: write one to clear, set wins over clear.
    if (wr_w && wsel_w == SIC_R_STS) begin
      state_d.sts = state_q.sts & ~pwdata_in[IRQ_W-1:0];
    end
    if (channel_event_in) begin
      state_d.sts[IRQ_FLAG_BIT] = 1'b1;
    end
    if (test_done_w) begin
      state_d.sts[IRQ_TEST_BIT] = 1'b1;
    end
    // Read data is captured in the setup phase so prdata is a flop.
    if (setup_w) begin
      state_d.rdata = RDATA_RST;
      state_d.slverr = (rsel_w == SIC_R_NONE);
      case (rsel_w)
        SIC_R_ONE: state_d.rdata[ONE_W-1:0] = state_q.one;
        SIC_R_TWO: begin
          state_d.rdata[TWO_MSB:TWO_LSB] = state_q.two;
          state_d.rdata[1] = test_ch1_result_in; // [RQ13]
          state_d.rdata[0] = test_ch0_result_in; // [RQ13]
        end
        SIC_R_STS: state_d.rdata[IRQ_W-1:0] = state_q.sts;
        SIC_R_MSK: state_d.rdata[IRQ_W-1:0] = state_q.msk;
        default: state_d.rdata = RDATA_RST;
      endcase
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state_q.one <= ONE_RST; // [RQ15]
      state_q.two <= TWO_RST; // [RQ15]
      state_q.sts <= IRQ_RST;
      state_q.msk <= IRQ_RST;
      state_q.rdata <= RDATA_RST;
      state_q.slverr <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Zero wait states keep the bus simple; the capture in setup costs
  // nothing because APB always has a setup cycle.
  assign pready_out = psel_in && penable_in;
  assign prdata_out = state_q.rdata;
  assign pslverr_out = psel_in && penable_in && state_q.slverr;
  assign interface_enable_out = state_q.one[ENABLE_BIT]; // [RQ5]
  assign test_insert_req_out = state_q.one[TEST_BIT]; // [RQ3]
  assign scan_event_flag0_out = state_q.one[FLAG0_BIT];
  // Force bits override the timing machine requests.
  assign dac_power_out = state_q.two[DAC_FORCE_BIT]
                         || tsm_dac_on_in; // [RQ6] [RQ7]
  assign cmp_power_out = state_q.two[CMP_FORCE_BIT] || tsm_cmp_on_in;
  assign cap_ground_out = state_q.two[CAP_GND_BIT];
  assign mid_supply_out = state_q.two[MID_SUP_BIT]
                          && !state_q.two[SH_EN_BIT]; // [RQ14]
  assign sample_hold_out = state_q.two[SH_EN_BIT];
  assign excitation_out = state_q.two[EXC_EN_BIT];
  assign irq_out = |(state_q.sts & state_q.msk);

  // Comparator routing lives in its own module.
  sic_comp_mux u_mux (
    .grp_in(state_q.two[CMP_GRP_BIT]),
    .single_in(state_q.two[SINGLE_SEL_BIT]),
    .fix3_in(state_q.two[FIX3_SEL_BIT]),
    .invert_in(state_q.two[CMP_INV_BIT]),
    .test_active_in(test_active_in),
    .test_chan_in(test_chan_in),
    .tch1_sel_in(state_q.two[TCH1_LSB+1:TCH1_LSB]),
    .tch0_sel_in(state_q.two[TCH0_LSB+1:TCH0_LSB]),
    .chan_sel_in(chan_sel_in),
    .sensor_in(sensor_channels_in),
    .alt_in(alternate_inputs_in),
    .common_in(common_alternate_input_in),
    .comp_raw_in(comp_raw_in),
    .comp_in_out(comp_in_out),
    .comp_result_out(comp_result_out)
  );

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  logic one_wr_w;
  assign one_wr_w = wr_w && wsel_w == SIC_R_ONE;

  flag_set_a: assert property ( // [RQ1]
    channel_event_in |=> scan_event_flag0_out ##0 irq_out == state_q.msk[0])
    else $error("event did not set the flag");

  flag_hold_a: assert property ( // [RQ2]
    scan_event_flag0_out && !one_wr_w |=> scan_event_flag0_out)
    else $error("flag cleared without a software write");

  test_req_a: assert property ( // [RQ3]
    one_wr_w && pwdata_in[TEST_BIT] |=> test_insert_req_out)
    else $error("test request not raised by write");

  test_clear_a: assert property ( // [RQ4]
    test_insert_req_out && test_cycle_done_in && !one_wr_w
    |=> !test_insert_req_out && state_q.sts[IRQ_TEST_BIT])
    else $error("test request not cleared after its cycle");

  enable_wr_a: assert property ( // [RQ5]
    one_wr_w |=> interface_enable_out == $past(pwdata_in[ENABLE_BIT]))
    else $error("enable does not follow written bit");

  dac_force_a: assert property ( // [RQ6]
    state_q.two[DAC_FORCE_BIT] |-> dac_power_out)
    else $error("forced DAC is off");

  dac_tsm_a: assert property ( // [RQ7]
    !state_q.two[DAC_FORCE_BIT] |-> dac_power_out == tsm_dac_on_in)
    else $error("DAC does not follow timing machine");

  comp_inv_a: assert property ( // [RQ8]
    comp_result_out == (comp_raw_in ^ state_q.two[CMP_INV_BIT]))
    else $error("comparator polarity wrong");

  sensor_route_a: assert property ( // [RQ9]
    !test_active_in && !state_q.two[CMP_GRP_BIT] && chan_sel_in != 2'h3
    |-> comp_in_out == sensor_channels_in[chan_sel_in])
    else $error("sensor channel not routed");

  common_route_a: assert property ( // [RQ10]
    !test_active_in && state_q.two[CMP_GRP_BIT]
    && state_q.two[SINGLE_SEL_BIT]
    |-> comp_in_out == common_alternate_input_in)
    else $error("common alternate input not routed");

  fix3_route_a: assert property ( // [RQ11]
    !test_active_in && state_q.two[CMP_GRP_BIT]
    && !state_q.two[SINGLE_SEL_BIT] && state_q.two[FIX3_SEL_BIT]
    |-> comp_in_out == alternate_inputs_in[3])
    else $error("alternate input three not routed");

  test_route_a: assert property ( // [RQ12]
    test_active_in && state_q.two[CMP_GRP_BIT]
    |-> comp_in_out == alternate_inputs_in[test_chan_in
        ? state_q.two[TCH1_LSB+1:TCH1_LSB]
        : state_q.two[TCH0_LSB+1:TCH0_LSB]])
    else $error("test channel input not routed");

  result_read_a: assert property ( // [RQ13]
    setup_w && rsel_w == SIC_R_TWO
    |=> prdata_out[1:0] == $past({test_ch1_result_in, test_ch0_result_in}))
    else $error("test results not reported");

  mid_supply_a: assert property ( // [RQ14]
    mid_supply_out |-> !sample_hold_out && state_q.two[MID_SUP_BIT])
    else $error("mid supply on with sample-hold");

  reset_zero_a: assert property ( // [RQ15]
    disable iff (1'b0) !rstn_in |=> state_q.one == ONE_RST
    && state_q.two == TWO_RST && !interface_enable_out)
    else $error("control bits not cleared by reset");

  flag_event_c: cover property (channel_event_in ##1 one_wr_w);
  test_cycle_c: cover property (one_wr_w ##[1:20] test_done_w);
  irq_fire_c: cover property (!irq_out ##1 irq_out);
  bad_addr_c: cover property (pslverr_out);

endmodule : sic_regs

// ### dv/sic_tsm_model.sv
// Purpose: Stand-in for the timing machine that runs inserted test cycles.
// Assumes: One clock shared with the control registers.
// Notes:   delay_in sets how long the machine waits before the test cycle.
module sic_tsm_model (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire logic [3:0] delay_in,
  output logic active_out,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_q;
  logic [4:0] cnt_q;
  // ==========================================================
  // Test cycle sequencer
  // ==========================================================
  // One request runs one test cycle; done is a single-cycle pulse.
  // The done guard stops the still-high request from starting a second one.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      busy_q <= 1'b0;
      cnt_q <= 5'h00;
      active_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (!busy_q && req_in && !done_out) begin
        busy_q <= 1'b1;
        cnt_q <= 5'h00;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 5'h01;
        active_out <= (cnt_q >= {1'b0, delay_in});
        if (cnt_q == {1'b0, delay_in} + 5'h02) begin
          done_out <= 1'b1;
          active_out <= 1'b0;
          busy_q <= 1'b0;
        end
      end
    end
  end
endmodule : sic_tsm_model

// ### dv/scan_interface_control_regs_bench.sv
// Purpose: Self-checking bench of the scan interface control registers.
// Assumes: APB master with zero-wait slave; one 50 ns clock.
// Notes:   Bench drives on rising edges, samples APB reads on rising edges and samples other outputs on falling edges.
module scan_interface_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sic_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ev = 1'b0, tb_act = 1'b0, tchan = 1'b0;
  logic tdac = 1'b0, tcmp = 1'b0, com = 1'b1, raw = 1'b0;
  logic r1 = 1'b0, r0 = 1'b0, pm_act, done;
  logic [1:0] csel = 2'h0;
  logic [3:0] sens = 4'h6, alt = 4'hc, dly = 4'h0;
  logic en, req, flag, dacp, cmpp, capg, mid, sh, exc, cin, cres, irq;
  int n_mismatch = 0, checks_done = 0;
  // ==========================================================
  // Clock, device and partner
  // ==========================================================
  always #25 clk = ~clk;
  sic_regs DUT (.ref_clk_in(clk), .rstn_in(rstn), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .channel_event_in(ev),
    .test_cycle_done_in(done), .test_active_in(pm_act | tb_act),
    .test_chan_in(tchan), .tsm_dac_on_in(tdac), .tsm_cmp_on_in(tcmp),
    .chan_sel_in(csel), .sensor_channels_in(sens),
    .alternate_inputs_in(alt), .common_alternate_input_in(com),
    .comp_raw_in(raw), .test_ch1_result_in(r1), .test_ch0_result_in(r0),
    .interface_enable_out(en), .test_insert_req_out(req),
    .scan_event_flag0_out(flag), .dac_power_out(dacp),
    .cmp_power_out(cmpp), .cap_ground_out(capg), .mid_supply_out(mid),
    .sample_hold_out(sh), .excitation_out(exc), .comp_in_out(cin),
    .comp_result_out(cres), .irq_out(irq));
  sic_tsm_model PM (.ref_clk_in(clk), .rstn_in(rstn), .req_in(req),
    .delay_in(dly), .active_out(pm_act), .done_out(done));
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // Setup, then access held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("apb_timeout", 32'h1, 32'h0);
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] ex, input logic exerr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, ex, r);
    chk({nm, "_err"}, {31'h0, exerr}, {31'h0, e});
  endtask : rdc
  // ==========================================================
  // Scenarios
  // ==========================================================
  // A mid-run reset must undo writes made before it.
  task automatic t_reset;
    wr(CTRL_ONE_ADDR, 32'h1);
    wr(CTRL_TWO_ADDR, 32'h8000);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("en_rst", 32'h0, en);
    chk("dac_rst", 32'h0, dacp);
    rdc("one_rst", CTRL_ONE_ADDR, 32'h0, 1'b0);
    rdc("two_rst", CTRL_TWO_ADDR, 32'h0, 1'b0);
    rdc("sts_rst", IRQ_STS_ADDR, 32'h0, 1'b0);
    rdc("msk_rst", IRQ_MSK_ADDR, 32'h0, 1'b0);
    wr(CTRL_ONE_ADDR, 32'h1);
    @(negedge clk);
    chk("en_on", 32'h1, en);
    rdc("one_en", CTRL_ONE_ADDR, 32'h1, 1'b0);
    wr(CTRL_ONE_ADDR, 32'h0);
    @(negedge clk);
    chk("en_off", 32'h0, en);
  endtask : t_reset
  // The flag stays pending until written to zero; status is sticky.
  task automatic t_flag;
    @(posedge clk);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    @(negedge clk);
    chk("flag_set", 32'h1, flag);
    chk("irq_masked", 32'h0, irq);
    repeat (6) @(negedge clk);
    chk("flag_held", 32'h1, flag);
    wr(IRQ_MSK_ADDR, 32'h1);
    @(negedge clk);
    chk("irq_on", 32'h1, irq);
    wr(CTRL_ONE_ADDR, 32'h0);
    @(negedge clk);
    chk("flag_clr", 32'h0, flag);
    chk("irq_sticky", 32'h1, irq);
    wr(IRQ_STS_ADDR, 32'h1);
    @(negedge clk);
    chk("irq_clr", 32'h0, irq);
  endtask : t_flag
  // One write yields exactly one test cycle, then the bit drops.
  task automatic t_test(input logic [3:0] d);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(posedge clk);
    dly <= d;
    wr(CTRL_ONE_ADDR, 32'h2);
    @(negedge clk);
    chk("req_set", 32'h1, req);
    while (done !== 1'b1 && n < 40) begin
      seen = seen | pm_act;
      @(negedge clk);
      n++;
    end
    if (n >= 40) begin
      chk("done_timeout", 32'h1, 32'h0);
      end_sim();
    end
    chk("cycle_ran", 32'h1, seen);
    @(negedge clk);
    chk("req_clr", 32'h0, req);
    repeat (20) @(negedge clk);
    chk("no_second", 32'h0, pm_act | req);
    rdc("sts_test", IRQ_STS_ADDR, 32'h2, 1'b0);
    // Only the test-done status bit is unmasked here.
    wr(IRQ_MSK_ADDR, 32'h2);
    @(negedge clk);
    chk("irq_test", 32'h1, irq);
    wr(IRQ_STS_ADDR, 32'h2);
    @(negedge clk);
    chk("irq_test_clr", 32'h0, irq);
  endtask : t_test
  // Power forcing and polarity, all combinations; mid-supply gating with sample-hold off and on.
  task automatic t_analog;
    for (int f = 0; f < 2; f++) begin
      for (int t = 0; t < 2; t++) begin
        wr(CTRL_TWO_ADDR, 32'(f) << 15 | 32'(f) << 14 | 32'(t) << 13);
        @(posedge clk);
        tdac <= t[0];
        tcmp <= t[0];
        raw <= f[0];
        @(negedge clk);
        chk("dac_pwr", f | t, dacp);
        chk("cmp_pwr", f | t, cmpp);
        chk("cmp_out", f ^ t, cres);
      end
    end
    @(posedge clk);
    r1 <= 1'b1;
    wr(CTRL_TWO_ADDR, 32'hffff_5557);
    rdc("two_rb", CTRL_TWO_ADDR, 32'h5556, 1'b0);
    @(negedge clk);
    chk("mid_on", 32'h1, mid);
    chk("sh_off", 32'h0, sh);
    chk("exc_on", 32'h1, exc);
    chk("capg_off", 32'h0, capg);
    wr(CTRL_TWO_ADDR, 32'h380);
    @(negedge clk);
    chk("mid_sh", 32'h0, mid);
    chk("sh_on", 32'h1, sh);
    chk("exc_off", 32'h0, exc);
    chk("capg_on", 32'h1, capg);
    // Swap the live results so each bit is seen high on its own.
    @(posedge clk);
    r1 <= 1'b0;
    r0 <= 1'b1;
    rdc("two_rb0", CTRL_TWO_ADDR, 32'h381, 1'b0);
    rdc("unmapped", 8'h10, 32'h0, 1'b1);
  endtask : t_analog
  // Normal routing, then test channel routing with the test fields.
  task automatic t_mux;
    logic ex;
    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 16; k++) begin
        wr(CTRL_TWO_ADDR, 32'(g) << 12 | 32'(k[3:2]) << 10);
        @(posedge clk);
        csel <= k[1:0];
        @(negedge clk);
        ex = g ? (k[3] ? com : k[2] ? alt[3] : alt[k[1:0]])
             : (k[1:0] == 2'h3 ? alt[3] : sens[k[1:0]]);
        chk("cmp_in", ex, cin);
      end
    end
    @(posedge clk);
    tb_act <= 1'b1;
    // The xor keeps the inverted index to two bits inside the cast.
    for (int k = 0; k < 16; k++) begin
      wr(CTRL_TWO_ADDR, 32'(k[3]) << 12 | (k[2] ?
        32'(k[1:0]) << 4 | 32'(k[1:0] ^ 2'h3) << 2 :
        32'(k[1:0] ^ 2'h3) << 4 | 32'(k[1:0]) << 2));
      @(posedge clk);
      tchan <= k[2];
      @(negedge clk);
      ex = k[1:0] == 2'h3 ? alt[3] : k[3] ? alt[k[1:0]] : sens[k[1:0]];
      chk("test_in", ex, cin);
    end
    @(posedge clk);
    tb_act <= 1'b0;
  endtask : t_mux
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_flag();
    t_test(4'h0);
    t_test(4'h9);
    t_analog();
    t_mux();
    end_sim();
  end
endmodule : scan_interface_control_regs_bench
